// ==== src/ileave_pkg.sv ====
// package: shared constants of the convolutional interleaver
// assumes: imported whole by every module of the block
package ileave_pkg;
    // configuration limits
    localparam int MAX_W = 256;
    localparam int MAX_B = 256;
    localparam int FIFO_DEPTH = 16;
    localparam int DLY_W = 16;
    localparam int ADDR_W = 12;
    // register byte addresses
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 12'h000;
    localparam logic [ADDR_W-1:0] STAT_ADDR = 12'h004;
    localparam logic [ADDR_W-1:0] CNT_ADDR = 12'h008;
    // control fields and reset values
    localparam int CTRL_DEINT = 0;
    localparam int CTRL_RUN = 1;
    localparam int CTRL_RESTART = 2;
    localparam logic CTRL_DEINT_RST = 1'b0;
    localparam logic CTRL_RUN_RST = 1'b1;
    // status fields
    localparam int STAT_BR_LSB = 0;
    localparam int STAT_LVL_LSB = 8;
    localparam int STAT_ARR = 16;
    localparam logic [31:0] CNT_RST = 32'h0000_0000;
endpackage : ileave_pkg

// ==== src/stream_if.sv ====
// interface: valid/ready word stream between block modules
// assumes: both ends on the same clock
`timescale 1ns/100ps
interface stream_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : stream_if

// ==== src/sym_fifo.sv ====
// sym_fifo: flip-flop FIFO with valid/ready on both sides
// assumes: one clock, async active-low reset, any depth from 2 up
`timescale 1ns/100ps
module sym_fifo
    import ileave_pkg::*;
#(
    parameter int W = 8,
    parameter int DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // streams
    stream_if.snk in_s,
    stream_if.src out_s,
    // fill level
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int AW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH+1);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [LW-1:0] cnt_r, cnt_nxt;
    logic in_rdy_r, in_rdy_nxt;
    logic push, pop;

    // wrap works for depths that are not powers of two
    function automatic logic [AW-1:0] next_idx(input logic [AW-1:0] p);
        return (int'(p) == DEPTH-1) ? '0 : p + 1'b1;
    endfunction : next_idx

    assign in_s.ready = in_rdy_r;
    assign out_s.valid = (cnt_r != '0);
    assign out_s.data = mem[rp_r];
    assign level = cnt_r;

    // pointer and level update
    always_comb begin
        push = in_s.valid && in_rdy_r;
        pop = out_s.ready && (cnt_r != '0);
        wp_nxt = push ? next_idx(wp_r) : wp_r;
        rp_nxt = pop ? next_idx(rp_r) : rp_r;
        cnt_nxt = cnt_r + LW'(push) - LW'(pop);
        in_rdy_nxt = (int'(cnt_nxt) != DEPTH); // registered, so no comb path
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            in_rdy_r <= 1'b0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
            in_rdy_r <= in_rdy_nxt;
        end
    end

    // storage carries no reset
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_r] <= in_s.data;
        end
    end

    a_fifo_no_over: assert property (@(posedge clk) disable iff (!rst_b)
        int'(cnt_r) == DEPTH |-> !in_rdy_r)
        else $error("fifo ready while full");
endmodule : sym_fifo

// ==== src/branch_store.sv ====
// branch_store: word storage for all branch delay lines
// assumes: one slot per stored symbol, read before write in a cycle
`timescale 1ns/100ps
module branch_store
    import ileave_pkg::*;
#(
    parameter int W = 8,
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    // clock
    input wire logic clk,
    // shared slot port
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [W-1:0] wdata,
    output logic [W-1:0] rdata
);
    logic [W-1:0] mem [DEPTH];

    // old word read out while the new one goes in
    assign rdata = mem[addr];

    // no reset: stored symbols survive a commutator reset
    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end
endmodule : branch_store

// ==== src/conv_ileave.sv ====
// conv_ileave: convolutional interleaver / deinterleaver with APB control
// assumes: din/vin from same-clock logic, APB master on clk, one clock
// assumes: MAXD at least the longest branch delay in use
`timescale 1ns/100ps
module conv_ileave
    import ileave_pkg::*;
#(
    parameter int W = 8,
    parameter int NB = 4,
    parameter int STEP = 2,
    parameter bit USE_ARRAY = 1'b0,
    parameter logic [NB*DLY_W-1:0] DELAYS = '0,
    parameter int MAXD = ((NB-1)*STEP > 0) ? (NB-1)*STEP : 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // symbol input
    input wire logic [W-1:0] din,
    input wire logic vin,
    output logic din_rdy,
    // symbol output
    output logic [W-1:0] dout,
    output logic vout
);
    // storage holds NB rows of MAXD slots, one row per branch
    localparam int BW = (NB > 1) ? $clog2(NB) : 1;
    localparam int PW = (MAXD > 1) ? $clog2(MAXD) : 1;
    localparam int SD = NB * MAXD;
    localparam int SAW = (SD > 1) ? $clog2(SD) : 1;
    localparam int LW = $clog2(FIFO_DEPTH+1);

    // commutator and delay-line state
    logic [BW-1:0] branch_r, branch_nxt;
    logic [PW-1:0] ptr_r [NB];
    logic [PW-1:0] ptr_nxt [NB];
    logic [W-1:0] dout_r, dout_nxt;
    logic vout_r, vout_nxt;
    logic [31:0] cnt_r, cnt_nxt;
    logic take;
    logic we;
    int cur_dly;
    logic [SAW-1:0] slot;
    logic [W-1:0] rd_data;
    logic [LW-1:0] level;

    // control registers and bus answer
    logic deint_r, deint_nxt;
    logic run_r, run_nxt;
    // restart is a one-cycle strobe from a ctrl write
    logic restart;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    logic setup, acc_wr;
    logic [31:0] rd_val;

    // buffer side and core side of the input fifo
    stream_if #(.W(W)) fi ();
    stream_if #(.W(W)) fo ();

    // delay of branch k; array delays override the mode
    function automatic int delay_of(input logic [BW-1:0] k, input logic deint);
        if (USE_ARRAY) begin
            return int'(DELAYS[int'(k)*DLY_W +: DLY_W]);
        end else if (deint) begin
            return (NB - 1 - int'(k)) * STEP;
        end else begin
            return int'(k) * STEP;
        end
    endfunction : delay_of

    // known register offsets
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        return (a == CTRL_ADDR) || (a == STAT_ADDR) || (a == CNT_ADDR);
    endfunction : addr_hit

    // input side: vin-qualified words enter the buffer
    assign fi.valid = vin;
    assign fi.data = din;
    assign din_rdy = fi.ready;
    // stalling the drain lets the buffer fill and push back on upstream
    assign fo.ready = run_r;

    // the buffer decouples upstream from a stalled core
    sym_fifo #(
        .W(W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .in_s(fi),
        .out_s(fo),
        .level(level)
    );

    // one slot per branch and position; MAXD must cover the longest delay
    assign slot = SAW'(int'(branch_r) * MAXD + int'(ptr_r[branch_r]));

    branch_store #(
        .W(W),
        .DEPTH(SD),
        .AW(SAW)
    ) u_store (
        .clk(clk),
        .we(we),
        .addr(slot),
        .wdata(fo.data),
        .rdata(rd_data)
    );

    // next commutator, pointer and output values
    always_comb begin
        take = fo.valid && run_r;
        cur_dly = delay_of(branch_r, deint_r);
        ptr_nxt = ptr_r;
        branch_nxt = branch_r;
        dout_nxt = dout_r;
        vout_nxt = take;
        cnt_nxt = cnt_r;
        we = 1'b0;
        if (take) begin
            // same branch feeds storage and output
            we = (cur_dly > 0);
            dout_nxt = (cur_dly > 0) ? rd_data : fo.data;
            if (cur_dly > 0) begin
                // a pointer beyond a shortened delay after a mode change wraps
                ptr_nxt[branch_r] = (int'(ptr_r[branch_r]) + 1 >= cur_dly) ?
                    '0 : ptr_r[branch_r] + 1'b1;
            end
            branch_nxt = (int'(branch_r) == NB-1) ? '0 : branch_r + 1'b1;
            cnt_nxt = cnt_r + 32'h0000_0001;
        end
        // restart wins over the step; a symbol taken with it still lands
        if (restart) begin
            branch_nxt = '0;
        end
    end

    // register the datapath state; storage itself is never cleared
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            branch_r <= '0;
            ptr_r <= '{default: '0};
            dout_r <= '0;
            vout_r <= 1'b0;
            cnt_r <= CNT_RST;
        end else begin
            branch_r <= branch_nxt;
            ptr_r <= ptr_nxt;
            dout_r <= dout_nxt;
            vout_r <= vout_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // outputs straight from their registers
    assign dout = dout_r;
    assign vout = vout_r;

    // read mux
    always_comb begin
        rd_val = '0;
        case (paddr)
            CTRL_ADDR: begin
                rd_val[CTRL_DEINT] = deint_r;
                rd_val[CTRL_RUN] = run_r;
            end
            STAT_ADDR: begin
                rd_val[STAT_BR_LSB +: BW] = branch_r;
                rd_val[STAT_LVL_LSB +: LW] = level;
                rd_val[STAT_ARR] = USE_ARRAY;
            end
            CNT_ADDR: begin
                rd_val = cnt_r;
            end
            default: begin
                rd_val = '0;
            end
        endcase
    end

    // apb: answer one cycle after setup; writes land in the access cycle
    always_comb begin
        setup = psel && !penable;
        acc_wr = psel && penable && pready_r && pwrite;
        pready_nxt = setup;
        pslverr_nxt = setup && !addr_hit(paddr);
        prdata_nxt = (setup && !pwrite) ? rd_val : '0;
        deint_nxt = deint_r;
        run_nxt = run_r;
        restart = 1'b0;
        // writes to read-only or unmapped offsets are dropped
        if (acc_wr && paddr == CTRL_ADDR) begin
            deint_nxt = pwdata[CTRL_DEINT];
            run_nxt = pwdata[CTRL_RUN];
            restart = pwdata[CTRL_RESTART]; // self-clearing
        end
    end

    // control and bus answer registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            deint_r <= CTRL_DEINT_RST;
            run_r <= CTRL_RUN_RST;
            prdata_r <= '0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            deint_r <= deint_nxt;
            run_r <= run_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // bus answer registers to the ports
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    // checks on the block's own behaviour
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_param_limits: assert property (
        W >= 1 && W <= MAX_W && NB >= 1 && NB <= MAX_B)
        else $error("width or branch count out of range");

    a_commut_step: assert property (
        take && !restart && int'(branch_r) < NB-1
        |=> branch_r == $past(branch_r) + 1'b1)
        else $error("commutator did not advance by one");

    a_commut_wrap: assert property (
        take && !restart && int'(branch_r) == NB-1 |=> branch_r == '0)
        else $error("commutator did not wrap to branch 0");

    a_idle_hold: assert property (
        !take && !restart |=> $stable(branch_r) && !vout_r)
        else $error("commutator moved without a valid symbol");

    a_vout_take: assert property (
        take |=> vout_r ##1 (vout_r == $past(take)))
        else $error("output valid not tied to accepted symbol");

    a_zero_ends: assert property (
        !USE_ARRAY && take &&
        ((!deint_r && branch_r == '0) || (deint_r && int'(branch_r) == NB-1))
        |=> dout_r == $past(fo.data))
        else $error("zero-delay branch did not pass straight through");

    a_ptr_step: assert property (
        take && cur_dly > 1 && int'(ptr_r[branch_r]) < cur_dly - 1
        |=> ptr_r[$past(branch_r)] == $past(ptr_r[branch_r]) + 1'b1)
        else $error("delay line pointer did not step");

    a_restart_home: assert property (
        restart |=> branch_r == '0)
        else $error("restart did not home the commutator");

    a_apb_ready: assert property (
        psel && !penable |=> pready_r ##1 !pready_r)
        else $error("apb answer not exactly one cycle after setup");

    // storage bounds and delay table
    a_delay_fits: assert property (
        take |-> cur_dly <= MAXD && (!USE_ARRAY || cur_dly >= 1))
        else $error("branch delay outside the storage bound");

    a_mode_ignored: assert property (
        USE_ARRAY |-> delay_of(branch_r, 1'b0) == delay_of(branch_r, 1'b1))
        else $error("array delays depend on the mode");

    // a visit leaves the pointer inside the branch's delay line
    a_ptr_range: assert property (
        take && cur_dly > 0
        |=> int'(ptr_r[$past(branch_r)]) < $past(cur_dly))
        else $error("delay line pointer beyond branch delay");

    // storage and count move only with an accepted symbol
    a_store_gate: assert property (
        !take |-> !we)
        else $error("storage written without an accepted symbol");

    a_count_step: assert property (
        take |=> cnt_r == $past(cnt_r) + 32'h0000_0001)
        else $error("symbol count did not step");

    a_count_hold: assert property (
        !take |=> $stable(cnt_r))
        else $error("symbol count moved without a symbol");

    a_stall_out: assert property (
        !run_r |=> !vout_r)
        else $error("output valid while the drain is stalled");

    // bus outputs rest at zero outside the access cycle
    a_apb_quiet: assert property (
        !pready_r |-> prdata_r == '0 && !pslverr_r)
        else $error("apb data or error outside the access cycle");

    a_apb_err: assert property (
        pslverr_r |-> pready_r)
        else $error("apb error without ready");

    c_wrap: cover property (take && int'(branch_r) == NB-1);
    c_deint: cover property (take && deint_r && cur_dly > 0);
    c_restart: cover property (restart && take);
    c_backpressure: cover property (vin && !din_rdy);
    c_array: cover property (take && USE_ARRAY && cur_dly > 0);
endmodule : conv_ileave

// ==== sim/sym_sink.sv ====
// sym_sink: downstream logic model, collects every output symbol
// assumes: same clock as the block, no backpressure on the output side
`timescale 1ns/100ps
module sym_sink #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // symbol stream from the block
    input wire logic [W-1:0] dout,
    input wire logic vout
);
    logic [W-1:0] got[$];

    // take a word only on a strobe, dout between strobes is stale
    always @(posedge clk) begin
        if (rst_b === 1'b1 && vout === 1'b1) begin
            got.push_back(dout);
        end
    end
endmodule : sym_sink

// ==== sim/tb_conv_ileave.sv ====
// tb_conv_ileave: self-checking bench for the convolutional interleaver
// assumes: apb master and symbol source here, sym_sink on the output side
`timescale 1ns/100ps
module tb_conv_ileave;
    import ileave_pkg::*;
    localparam int NB = 4;
    localparam int STEP = 2;
    // per-branch delays of the array instance, branch 0 in the low field
    localparam logic [NB*DLY_W-1:0] ADELAYS =
        {16'h0001, 16'h0003, 16'h0002, 16'h0001};
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr, din_rdy, vin = 1'b0, vout;
    logic [7:0] din = '0, dout;
    logic [7:0] dout_a;
    logic vout_a;
    logic [31:0] rd, rd_a, prdata_a;
    logic err;
    int num_errors = 0;
    int cmp_count = 0;

    conv_ileave #(.W(8), .NB(NB), .STEP(STEP)) uut (
        .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .din(din), .vin(vin), .din_rdy(din_rdy), .dout(dout),
        .vout(vout));
    sym_sink #(.W(8)) sink (.clk(clk), .rst_b(rst_b), .dout(dout), .vout(vout));
    // array-mode copy on the same bus and stream; its handshakes match uut's
    conv_ileave #(.W(8), .NB(NB), .STEP(STEP), .USE_ARRAY(1'b1), .DELAYS(ADELAYS)) uut_arr (
        .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata_a), .pready(), .pslverr(),
        .din(din), .vin(vin), .din_rdy(), .dout(dout_a), .vout(vout_a));
    sym_sink #(.W(8)) sink_a (.clk(clk), .rst_b(rst_b), .dout(dout_a), .vout(vout_a));

    // 125 MHz clock
    always #4 clk = ~clk;

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s: got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk

    // one apb transfer, request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        rd_a = prdata_a;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge, so a following call never re-drives in this step
        @(posedge clk);
    endtask : apb

    // valid held until the word is taken; caller drops vin after the last
    task automatic send(input logic [7:0] d);
        vin <= 1'b1;
        din <= d;
        @(posedge clk);
        while (din_rdy !== 1'b1) @(posedge clk);
    endtask : send

    // expected branch delay: array fields when arr, else the step profile
    function automatic int dly(input bit arr, input bit deint, input int k);
        if (arr) begin
            case (k)
                0: return 1;
                1: return 2;
                2: return 3;
                default: return 1;
            endcase
        end
        return deint ? (NB - 1 - k) * STEP : k * STEP;
    endfunction : dly

    // registers after reset and an unmapped access
    task automatic t_regs();
        apb(1'b0, CTRL_ADDR, '0);
        chk(rd, 32'h0000_0002, "ctrl reset");
        apb(1'b0, CNT_ADDR, '0);
        chk(rd, CNT_RST, "count reset");
        apb(1'b0, 12'h00c, '0);
        chk({31'h0, err}, 32'h1, "unmapped error");
        chk(rd, 32'h0, "unmapped data");
    endtask : t_regs

    // restart, stream symbols back to back, compare against branch delays
    task automatic t_stream(input bit deint, input int cnt);
        logic [7:0] sent[$];
        int d;
        apb(1'b1, CTRL_ADDR, {29'h0, 1'b1, 1'b1, deint});
        sink.got.delete();
        sink_a.got.delete();
        for (int i = 0; i < cnt; i++) begin
            sent.push_back(8'(i * 7 + 3));
            send(8'(i * 7 + 3));
        end
        vin <= 1'b0;
        repeat (4) @(posedge clk);
        chk(sink.got.size(), cnt, "output count");
        chk(sink_a.got.size(), cnt, "array output count");
        // older symbols of a branch come from before the restart
        for (int n = 0; n < cnt && n < sink.got.size(); n++) begin
            d = dly(1'b0, deint, n % NB);
            if (n >= NB * d) begin
                chk(sink.got[n], sent[n - NB * d], "branch delay");
            end
        end
        // array delays must not follow the mode bit
        for (int n = 0; n < cnt && n < sink_a.got.size(); n++) begin
            d = dly(1'b1, deint, n % NB);
            if (n >= NB * d) begin
                chk(sink_a.got[n], sent[n - NB * d], "array delay");
            end
        end
    endtask : t_stream

    // reset homes the commutator and clears the symbol count
    task automatic t_reset();
        for (int i = 0; i < 3; i++) send(8'h50 + 8'(i));
        vin <= 1'b0;
        repeat (4) @(posedge clk);
        apb(1'b0, STAT_ADDR, '0);
        chk({24'h0, rd[7:0]}, 32'h3, "branch after three");
        rst_b <= 1'b0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        apb(1'b0, STAT_ADDR, '0);
        chk({24'h0, rd[7:0]}, 32'h0, "branch after reset");
        sink.got.delete();
        send(8'hc6);
        vin <= 1'b0;
        repeat (4) @(posedge clk);
        chk({24'h0, sink.got[0]}, 32'h0000_00c6, "branch 0 after reset");
        apb(1'b0, CNT_ADDR, '0);
        chk(rd, 32'h1, "count one");
    endtask : t_reset

    // stalled drain: fifo fills and refuses, then empties with no loss
    task automatic t_fifo();
        apb(1'b1, CTRL_ADDR, 32'h0000_0004);
        sink.got.delete();
        for (int i = 0; i < FIFO_DEPTH; i++) send(8'(i));
        vin <= 1'b0;
        repeat (2) @(posedge clk);
        chk({31'h0, din_rdy}, 32'h0, "fifo full refuses");
        apb(1'b0, STAT_ADDR, '0);
        chk({27'h0, rd[12:8]}, 32'(FIFO_DEPTH), "fifo level");
        chk({27'h0, rd[16]}, 32'h0, "step mode");
        chk({31'h0, rd_a[16]}, 32'h1, "array mode flag");
        chk(sink.got.size(), 0, "no output while stalled");
        apb(1'b1, CTRL_ADDR, 32'h0000_0002);
        repeat (FIFO_DEPTH + 6) @(posedge clk);
        chk(sink.got.size(), FIFO_DEPTH, "drained count");
        chk({31'h0, din_rdy}, 32'h1, "fifo empty takes");
        apb(1'b0, CNT_ADDR, '0);
        chk(rd, 32'(FIFO_DEPTH + 1), "count after drain");
    endtask : t_fifo

    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        num_errors++;
        finish_test();
    end

    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_regs();
        t_stream(1'b0, 32);
        t_stream(1'b1, 32);
        t_stream(1'b0, 32);
        t_reset();
        t_fifo();
        finish_test();
    end
endmodule : tb_conv_ileave
